// >>> hw/phy_basic_control_bits.sv
`timescale 1ns/1ps
module phy_basic_control_bits
   import phy_ctrl_pkg::*;
#(
   parameter int RESET_CYCLES = PD_WAIT_CYCLES
)
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic mdc_i,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe_o,
   input wire logic [4:0] phy_addr_i,
   input wire logic speed_msb_strap_i,
   input wire logic link_up_i,
   input wire an_result_t an_result_i,
   output logic loopback_o,
   output logic isolate_o,
   output logic power_down_o,
   output logic [1:0] speed_o,
   output logic duplex_o,
   output logic auto_mdix_o,
   output logic mdix_sel_o,
   output logic soft_reset_o,
   output logic an_restart_o,
   output logic global_reset_o
);
   typedef struct packed {
      mgmt_state_t st;
      logic [4:0] cnt;
      logic [15:0] shift;
      logic is_read;
      logic hit;
      logic [4:0] regad;
      logic mdc_prev;
      logic mdio_out;
      logic mdio_oe;
      logic [15:0] ctrl;
      logic [15:0] mdix;
      logic link;
      logic [1:0] speed;
      logic duplex;
      logic [BUSY_W-1:0] busy;
      logic global_rst;
      logic soft_rst;
      logic an_restart;
      logic [2:0] strap_cnt;
      logic strap_msb;
   } core_t;

   localparam logic [BUSY_W-1:0] BUSY_LOAD = BUSY_W'(RESET_CYCLES);

   core_t r;
   core_t next_r;
   logic [2:0] pins;

   pin_sync #(.W(3)) u_sync (
      .clock_i(clock_i),
      .nrst_i(nrst_i),
      .d_i({speed_msb_strap_i, mdio_i, mdc_i}),
      .q_o(pins)
   );

   // read view of the register space; unused indices read as zero
   function automatic logic [15:0] rd_word(input logic [4:0] a,
                                           input logic [15:0] ctrl,
                                           input logic [15:0] mdix,
                                           input logic link);
      logic [15:0] v;
      v = 16'h0000;
      unique case (a)
         REG_BASIC_CONTROL: v = ctrl;
         REG_BASIC_STATUS:
         begin
            v[STS_LINK] = link;
            v[STS_AN_ABLE] = 1'b1;
         end
         REG_MDIX_CONTROL: v = mdix;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction : rd_word

   function automatic logic [15:0] ctl_default(input logic msb);
      logic [15:0] v;
      v = CTL_RESET;
      v[CTL_SPEED_MSB] = msb;
      return v;
   endfunction : ctl_default

   always_comb
   begin
      logic rise;
      logic bit_in;
      logic ready;
      logic [15:0] w;
      rise = 1'b0;
      bit_in = 1'b0;
      ready = 1'b0;
      w = 16'h0000;
      next_r = r;
      next_r.soft_rst = 1'b0;
      next_r.an_restart = 1'b0;
      next_r.mdc_prev = pins[0];
      rise = pins[0] & ~r.mdc_prev;
      bit_in = pins[1];
      // strap level is only trusted once the synchroniser has settled
      // the synchroniser output is valid only from the fourth edge on,
      // so the strap is read one edge after the count reaches settle
      if (r.strap_cnt != STRAP_SETTLE + 3'h1)
      begin
         next_r.strap_cnt = r.strap_cnt + 3'h1;
      end
      if (r.strap_cnt == STRAP_SETTLE)
      begin
         next_r.strap_msb = pins[2];
         next_r.ctrl[CTL_SPEED_MSB] = pins[2];
      end
      if (r.busy != '0)
      begin
         next_r.busy = r.busy - BUSY_W'(1);
      end
      ready = (r.strap_cnt == STRAP_SETTLE + 3'h1) && (r.busy == '0);
      // stale link-up is allowed while powered down
      if (!r.ctrl[CTL_POWER_DOWN])
      begin
         next_r.link = link_up_i;
      end
      // frames are dropped during the reset window rather than half-served
      if (!ready)
      begin
         next_r.st = ST_IDLE;
         next_r.mdio_oe = 1'b0;
      end
      else if (rise)
      begin
         next_r.cnt = r.cnt + 5'h1;
         unique case (r.st)
            ST_IDLE:
            begin
               if (!bit_in)
               begin
                  next_r.st = ST_START;
               end
            end
            ST_START:
            begin
               next_r.cnt = 5'h0;
               next_r.st = bit_in ? ST_OP : ST_IDLE;
            end
            ST_OP:
            begin
               next_r.shift = {r.shift[14:0], bit_in};
               if (r.cnt == 5'h1)
               begin
                  next_r.is_read = ({r.shift[0], bit_in} == OP_READ);
                  next_r.cnt = 5'h0;
                  if (({r.shift[0], bit_in} == OP_READ)
                      || ({r.shift[0], bit_in} == OP_WRITE))
                  begin
                     next_r.st = ST_PHYAD;
                  end
                  else
                  begin
                     next_r.st = ST_IDLE;
                  end
               end
            end
            ST_PHYAD:
            begin
               next_r.shift = {r.shift[14:0], bit_in};
               if (r.cnt == 5'h4)
               begin
                  next_r.hit = ({r.shift[3:0], bit_in} == phy_addr_i);
                  next_r.cnt = 5'h0;
                  next_r.st = ST_REGAD;
               end
            end
            ST_REGAD:
            begin
               next_r.shift = {r.shift[14:0], bit_in};
               if (r.cnt == 5'h4)
               begin
                  next_r.regad = {r.shift[3:0], bit_in};
                  next_r.cnt = 5'h0;
                  next_r.st = ST_TA;
               end
            end
            ST_TA:
            begin
               if (r.cnt == 5'h0)
               begin
                  if (r.is_read && r.hit)
                  begin
                     next_r.mdio_oe = 1'b1;
                     next_r.mdio_out = 1'b0;
                     next_r.shift = rd_word(r.regad, r.ctrl, r.mdix,
                                            r.link);
                  end
               end
               else
               begin
                  next_r.cnt = 5'h0;
                  next_r.st = ST_DATA;
                  next_r.mdio_out = r.shift[15];
               end
            end
            ST_DATA:
            begin
               if (r.is_read)
               begin
                  next_r.mdio_out = r.shift[14];
                  next_r.shift = {r.shift[14:0], 1'b0};
               end
               else
               begin
                  next_r.shift = {r.shift[14:0], bit_in};
               end
               if (r.cnt == 5'hF)
               begin
                  next_r.st = ST_IDLE;
                  next_r.mdio_oe = 1'b0;
                  w = {r.shift[14:0], bit_in};
                  if (!r.is_read && r.hit)
                  begin
                     if (r.regad == REG_BASIC_CONTROL)
                     begin
                        if (w[CTL_SOFT_RESET])
                        begin
                           // self-clearing: defaults reload, bit reads 0
                           next_r.ctrl = ctl_default(r.strap_msb);
                           next_r.soft_rst = 1'b1;
                           next_r.busy = BUSY_LOAD;
                        end
                        else if (r.ctrl[CTL_POWER_DOWN]
                                 && !w[CTL_POWER_DOWN])
                        begin
                           next_r.ctrl = ctl_default(r.strap_msb);
                           next_r.busy = BUSY_LOAD;
                        end
                        else
                        begin
                           next_r.ctrl = w & CTL_RW_MASK;
                           next_r.an_restart = w[CTL_AN_RESTART];
                        end
                     end
                     else if (r.regad == REG_MDIX_CONTROL)
                     begin
                        next_r.mdix = w;
                     end
                  end
               end
            end
            default:
            begin
               next_r.st = ST_IDLE;
               next_r.mdio_oe = 1'b0;
            end
         endcase
      end
      next_r.global_rst = (next_r.busy != '0);
      // negotiated result wins while negotiation is on
      if (r.ctrl[CTL_AN_ENABLE])
      begin
         next_r.speed = an_result_i.speed;
         next_r.duplex = an_result_i.duplex;
      end
      else
      begin
         next_r.duplex = r.ctrl[CTL_DUPLEX];
         // reserved code keeps the last speed instead of a guess
         if ({r.ctrl[CTL_SPEED_MSB], r.ctrl[CTL_SPEED_LSB]}
             != SPEED_RSVD)
         begin
            next_r.speed = {r.ctrl[CTL_SPEED_MSB],
                            r.ctrl[CTL_SPEED_LSB]};
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r <= '0;
         r.st <= ST_IDLE;
         r.ctrl <= CTL_RESET;
         r.mdix <= MDIX_RESET;
         r.speed <= SPEED_10;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign mdio_o = r.mdio_out;
   assign mdio_oe_o = r.mdio_oe;
   assign loopback_o = r.ctrl[CTL_LOOPBACK];
   assign isolate_o = r.ctrl[CTL_ISOLATE];
   assign power_down_o = r.ctrl[CTL_POWER_DOWN];
   assign speed_o = r.speed;
   assign duplex_o = r.duplex;
   assign auto_mdix_o = r.ctrl[CTL_AN_ENABLE];
   assign mdix_sel_o = r.mdix[MDIX_MANUAL_SEL];
   assign soft_reset_o = r.soft_rst;
   assign an_restart_o = r.an_restart;
   assign global_reset_o = r.global_rst;
endmodule : phy_basic_control_bits

// >>> hw/phy_ctrl_pkg.sv
package phy_ctrl_pkg;
   // management register space
   localparam int NUM_REGS = 32;
   localparam int STD_REGS = 16;
   localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
   localparam logic [4:0] REG_MDIX_CONTROL = 5'h1C;
   // basic control fields
   localparam int CTL_SOFT_RESET = 15;
   localparam int CTL_LOOPBACK = 14;
   localparam int CTL_SPEED_LSB = 13;
   localparam int CTL_AN_ENABLE = 12;
   localparam int CTL_POWER_DOWN = 11;
   localparam int CTL_ISOLATE = 10;
   localparam int CTL_AN_RESTART = 9;
   localparam int CTL_DUPLEX = 8;
   localparam int CTL_SPEED_MSB = 6;
   localparam logic [15:0] CTL_RW_MASK = 16'h7DC0;
   localparam logic [15:0] CTL_RESET = 16'h1100;
   // basic status and crossover fields
   localparam int STS_LINK = 2;
   localparam int STS_AN_ABLE = 3;
   localparam int MDIX_MANUAL_SEL = 6;
   localparam logic [15:0] MDIX_RESET = 16'h0000;
   // speed codes {msb, lsb}
   localparam logic [1:0] SPEED_10 = 2'h0;
   localparam logic [1:0] SPEED_100 = 2'h1;
   localparam logic [1:0] SPEED_1000 = 2'h2;
   localparam logic [1:0] SPEED_RSVD = 2'h3;
   // management frame opcodes
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_WRITE = 2'h1;
   // timing
   localparam int CLK_FREQ_KHZ = 125_000;
   localparam int PD_WAIT_TIME_MS = 1;
   localparam int PD_WAIT_CYCLES = PD_WAIT_TIME_MS * CLK_FREQ_KHZ;
   localparam int BUSY_W = 17;
   localparam logic [2:0] STRAP_SETTLE = 3'h4;

   typedef struct packed {
      logic [1:0] speed;
      logic duplex;
   } an_result_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_START = 3'b001,
      ST_OP = 3'b011,
      ST_PHYAD = 3'b010,
      ST_REGAD = 3'b110,
      ST_TA = 3'b111,
      ST_DATA = 3'b101
   } mgmt_state_t;
endpackage : phy_ctrl_pkg

// >>> hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
   import phy_ctrl_pkg::*;
#(
   parameter int W = 1
)
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } sync_t;

   sync_t r;
   sync_t next_r;

   always_comb
   begin
      next_r = r;
      next_r.s1 = d_i;
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // only accept a level once two settled stages agree
      for (int i = 0; i < W; i++)
      begin
         if (r.s2[i] == r.s3[i])
         begin
            next_r.q[i] = r.s3[i];
         end
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         r <= '0;
      end
      else
      begin
         r <= next_r;
      end
   end

   assign q_o = r.q;
endmodule : pin_sync

// >>> verification/mgmt_host.sv
`timescale 1ns/1ps
module mgmt_host
   import phy_ctrl_pkg::*;
#(
   parameter int HALF = 10,
   parameter int WAIT = 20
)
(
   input wire logic clock_i,
   input wire logic mdio_i,
   output logic mdc_o,
   output logic mdio_o,
   output logic mdio_oe_o
);
   logic pd = 1'b0;
   initial
   begin
      mdc_o = 1'b0;
      mdio_o = 1'b1;
      mdio_oe_o = 1'b0;
   end
   task automatic xfer(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [33:0] fr;
      // two idle ones, then the start pattern 0,1
      fr = {4'hD, op, pa, ra, 2'h2, wd};
      rd = 16'h0000;
      for (int i = 0; i < 34; i++)
      begin
         @(posedge clock_i);
         #1;
         mdio_oe_o = !(op == OP_READ && i >= 16);
         mdio_o = fr[33-i];
         repeat (HALF) @(posedge clock_i);
         if (i >= 18)
            rd = {rd[14:0], mdio_i};
         #1 mdc_o = 1'b1;
         repeat (HALF) @(posedge clock_i);
         #1 mdc_o = 1'b0;
      end
      mdio_oe_o = 1'b0;
      if (op == OP_READ && ra == REG_BASIC_STATUS && pd)
         rd[STS_LINK] = 1'b0;
      if (op == OP_WRITE && ra == REG_BASIC_CONTROL)
      begin
         if (wd[CTL_SOFT_RESET] || (pd && !wd[CTL_POWER_DOWN]))
            repeat (WAIT + 8) @(posedge clock_i);
         pd = wd[CTL_POWER_DOWN] && !wd[CTL_SOFT_RESET];
      end
   endtask : xfer
endmodule : mgmt_host

// >>> verification/phy_basic_control_bits_chk.sv
`timescale 1ns/1ps
module phy_basic_control_bits_chk
   import phy_ctrl_pkg::*;
#(
   parameter int RESET_CYCLES = PD_WAIT_CYCLES
)
(
   input wire logic clock_i,
   input wire logic nrst_i,
   input wire logic mdio_oe_o,
   input wire an_result_t an_result_i,
   input wire logic loopback_o,
   input wire logic power_down_o,
   input wire logic [1:0] speed_o,
   input wire logic duplex_o,
   input wire logic auto_mdix_o,
   input wire logic soft_reset_o,
   input wire logic an_restart_o,
   input wire logic global_reset_o
);
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!nrst_i);
   logic [16:0] win_len;
   always_ff @(posedge clock_i or negedge nrst_i)
   begin
      if (!nrst_i)
         win_len <= 17'h0_0000;
      else if (global_reset_o)
         win_len <= win_len + 17'h0_0001;
      else
         win_len <= 17'h0_0000;
   end
   a_srst_pulse: assert property (
      soft_reset_o |=> !soft_reset_o) else $error("reset pulse long");
   a_srst_window: assert property (
      soft_reset_o |-> ##[0:2] global_reset_o) else $error("no window");
   a_srst_defaults: assert property (
      soft_reset_o |-> ##[1:4] (auto_mdix_o && !loopback_o))
      else $error("no reload");
   a_restart_pulse: assert property (
      an_restart_o |=> !an_restart_o) else $error("restart long");
   a_reset_values: assert property (
      $rose(nrst_i) |-> auto_mdix_o && !loopback_o && !power_down_o)
      else $error("bad reset values");
   // three cycles so the control-to-speed lag has settled
   a_an_follow: assert property (
      auto_mdix_o [*3] |-> speed_o == $past(an_result_i.speed)
      && duplex_o == $past(an_result_i.duplex)) else $error("no an");
   a_rsvd_kept: assert property (
      !auto_mdix_o |-> speed_o != SPEED_RSVD) else $error("rsvd speed");
   a_pd_exit: assert property (
      $fell(power_down_o) |-> ##[0:2] global_reset_o)
      else $error("no pd reset");
   a_window_quiet: assert property (
      global_reset_o |-> !mdio_oe_o) else $error("answer in window");
   a_window_len: assert property (
      $fell(global_reset_o) |-> win_len >= RESET_CYCLES - 1
      && win_len <= RESET_CYCLES + 1) else $error("window length");
   cover property (soft_reset_o);
   cover property (an_restart_o);
   cover property ($fell(power_down_o));
   cover property (!auto_mdix_o && speed_o == SPEED_1000);
endmodule : phy_basic_control_bits_chk
bind phy_basic_control_bits phy_basic_control_bits_chk #(
   .RESET_CYCLES(RESET_CYCLES)) u_chk (.clock_i, .nrst_i, .mdio_oe_o,
   .an_result_i, .loopback_o, .power_down_o, .speed_o, .duplex_o,
   .auto_mdix_o, .soft_reset_o, .an_restart_o, .global_reset_o);

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
   import phy_ctrl_pkg::*;
   localparam logic [4:0] ADDR = 5'h03;
   logic clock_i = 1'b0;
   logic nrst_i = 1'b0;
   logic link_up_i = 1'b1;
   an_result_t an_result_i = '{speed: SPEED_100, duplex: 1'b1};
   logic mdc, host_d, host_oe, dev_d, dev_oe, mdio;
   logic loopback_o, isolate_o, power_down_o, duplex_o, auto_mdix_o;
   logic mdix_sel_o, soft_reset_o, an_restart_o, global_reset_o;
   logic [1:0] speed_o;
   logic [15:0] w;
   int n_fail = 0;
   int num_checks = 0;
   int n_srst = 0;
   int n_anr = 0;
   int n_grst = 0;
   int g0 = 0;
   always #4 clock_i = ~clock_i;
   // released line floats high through the pull-up
   assign mdio = dev_oe ? dev_d : (host_oe ? host_d : 1'b1);
   always @(posedge clock_i)
   begin
      n_srst <= n_srst + int'(soft_reset_o === 1'b1);
      n_anr <= n_anr + int'(an_restart_o === 1'b1);
      n_grst <= n_grst + int'(global_reset_o === 1'b1);
   end
   phy_basic_control_bits #(.RESET_CYCLES(20)) u_phy_basic_control_bits (
      .clock_i, .nrst_i, .mdc_i(mdc), .mdio_i(mdio), .mdio_o(dev_d),
      .mdio_oe_o(dev_oe), .phy_addr_i(ADDR), .speed_msb_strap_i(1'b0),
      .link_up_i, .an_result_i, .loopback_o, .isolate_o, .power_down_o,
      .speed_o, .duplex_o, .auto_mdix_o, .mdix_sel_o, .soft_reset_o,
      .an_restart_o, .global_reset_o);
   mgmt_host #(.HALF(10), .WAIT(20)) u_mgmt_host (.clock_i,
      .mdio_i(mdio), .mdc_o(mdc), .mdio_o(host_d), .mdio_oe_o(host_oe));
   task automatic check(input string what, input logic [15:0] exp,
      input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
      logic [15:0] dummy;
      u_mgmt_host.xfer(OP_WRITE, ADDR, ra, wd, dummy);
   endtask : wr
   task automatic rdc(input string what, input logic [4:0] ra,
      input logic [15:0] exp, input logic [4:0] pa = ADDR);
      logic [15:0] got;
      u_mgmt_host.xfer(OP_READ, pa, ra, 16'h0000, got);
      check(what, exp, got);
   endtask : rdc
   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report
   initial
   begin
      repeat (60000) @(posedge clock_i);
      n_fail++;
      final_report();
   end
   initial
   begin
      repeat (4) @(posedge clock_i);
      #1 nrst_i = 1'b1;
      repeat (12) @(posedge clock_i);
      rdc("ctrl reset", REG_BASIC_CONTROL, 16'h1100);
      rdc("status", REG_BASIC_STATUS, 16'h000C);
      wr(REG_MDIX_CONTROL, 16'h0040);
      rdc("mdix reg", REG_MDIX_CONTROL, 16'h0040);
      wr(5'h10, 16'hFFFF);
      rdc("vendor gap", 5'h10, 16'h0000);
      rdc("other addr", 5'h00, 16'hFFFF, ADDR ^ 5'h01);
      $display("map test done");
      for (int c = 0; c < 3; c++)
      begin
         w = {2'h1, c[0], 5'h01, 1'b0, c[1], 6'h3F};
         wr(REG_BASIC_CONTROL, w);
         check("speed", 16'(c), {14'h0000, speed_o});
         rdc("ctrl rw", REG_BASIC_CONTROL, w & 16'hFFC0);
      end
      check("auto mdix", 16'h0000, {15'h0000, auto_mdix_o});
      check("mdix sel", 16'h0001, {15'h0000, mdix_sel_o});
      wr(REG_BASIC_CONTROL, 16'h6540);
      check("rsvd", 16'h0002, {14'h0000, speed_o});
      check("loopback", 16'h0001, {15'h0000, loopback_o});
      check("isolate", 16'h0001, {15'h0000, isolate_o});
      $display("speed test done");
      wr(REG_BASIC_CONTROL, 16'h1000);
      check("an speed", 16'h0001, {14'h0000, speed_o});
      check("an duplex", 16'h0001, {15'h0000, duplex_o});
      wr(REG_BASIC_CONTROL, 16'h1200);
      check("restarts", 16'h0001, 16'(n_anr));
      rdc("restart clr", REG_BASIC_CONTROL, 16'h1000);
      $display("negotiation test done");
      wr(REG_BASIC_CONTROL, 16'hD000);
      check("soft resets", 16'h0001, 16'(n_srst));
      rdc("ctrl after rst", REG_BASIC_CONTROL, 16'h1100);
      check("loopback rst", 16'h0000, {15'h0000, loopback_o});
      $display("soft reset test done");
      wr(REG_BASIC_CONTROL, 16'h1800);
      check("power down", 16'h0001, {15'h0000, power_down_o});
      @(posedge clock_i);
      #1 link_up_i = 1'b0;
      rdc("status pd", REG_BASIC_STATUS, 16'h0008);
      g0 = n_grst;
      wr(REG_BASIC_CONTROL, 16'h1000);
      check("pd window", 16'h0001, 16'(n_grst > g0));
      rdc("ctrl after pd", REG_BASIC_CONTROL, 16'h1100);
      $display("power down test done");
      final_report();
   end
endmodule : testbench
